/* core/ccms_core.sv */
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module ccms_core import ccms_pkg::*; #(
   parameter int IM_DEPTH = 64,
   parameter int TM_DEPTH = 64,
   parameter logic [17:0] PROT_LIMIT = 18'h20000
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [15:0] CPU0_WORD,
   input wire logic [15:0] CPU1_WORD,
   input wire logic CPU_VALID,
   input wire logic CPU0_FAULT,
   input wire logic CPU1_FAULT,
   output logic [15:0] BUS_OUT,
   output logic BUS_VALID,
   output logic ACTIVE_CPU,
   output logic MISMATCH,
   output logic BASE_TICK,
   output logic [7:0] TM_UNIT_SEL,
   output logic TM_START
);
   localparam int IMI = $clog2(IM_DEPTH);
   localparam int TMI = $clog2(TM_DEPTH);

   typedef struct packed {
      logic awready, wready, bvalid, arready, rvalid;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
      logic aw_have, w_have;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic lock_open;
      logic [IM_AW-1:0] im_addr;
      logic [IM_W-1:0] im_wdata, im_rdata;
      logic [TM_AW-1:0] tm_addr;
      logic [15:0] tm_wdata;
      logic [16:0] tm_rdata;
      logic tm_badpar;
      ccms_state_t state;
      logic [7:0] cnt;
      logic [4:0] tick_cnt;
      logic tick;
      logic prot, fetch_err, par_err, mism, addr_err;
      logic act, sb_ok;
      logic [15:0] bus;
      logic bus_v;
      logic [7:0] unit_sel;
      logic tm_start;
      logic [IM_DEPTH-1:0][IM_W-1:0] im_mem;
      logic [TM_DEPTH-1:0][16:0] tm_mem;
   } ccms_regs_t;

   ccms_regs_t r_q, r_d;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = o;
      for (int i = 0; i < 4; i++)
         if (s[i])
            m[i*8 +: 8] = n[i*8 +: 8];
      return m;
   endfunction

   function automatic logic [31:0] order_fields(input logic [ORD_W-1:0] o);
      logic [31:0] f;
      f = 32'h0;
      f[31:29] = o[ORD_GRP_LSB +: 3];
      f[28:24] = o[ORD_INS_LSB +: 5];
      f[18:16] = o[ORD_IDX_LSB +: 3];
      f[DAR_W-1:0] = o[DAR_W-1:0];
      return f;
   endfunction

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb
   begin
      logic [31:0] v;
      logic [31:0] st;
      logic wr_go;
      logic [2:0] tu;
      v = 32'h0;
      wr_go = 1'b0;
      tu = r_q.tm_addr[TM_UNIT_LSB +: 3];
      r_d = r_q;
      st = 32'h0;
      st[ST_BUSY] = (r_q.state != CCMS_IDLE);
      st[ST_PROT] = r_q.prot;
      st[ST_FETCH] = r_q.fetch_err;
      st[ST_PAR] = r_q.par_err;
      st[ST_MISM] = r_q.mism;
      st[ST_ACT] = r_q.act;
      st[ST_SBOK] = r_q.sb_ok;
      st[ST_ADDR] = r_q.addr_err;

      // 2 MHz base tick for the processor side
      r_d.tick = 1'b0;
      if (r_q.tick_cnt == 5'(TICK_CYC - 1))
      begin
         r_d.tick_cnt = 5'h0;
         r_d.tick = 1'b1;
      end
      else
         r_d.tick_cnt = r_q.tick_cnt + 5'h1;

      // ---------------------------------------------------------
      // memory access sequencer
      // ---------------------------------------------------------
      r_d.tm_start = 1'b0;
      if (r_q.state != CCMS_IDLE)
         r_d.cnt = r_q.cnt + 8'h1;
      case (r_q.state)
         CCMS_IDLE:
            r_d.cnt = 8'h0;
         CCMS_IM_RD:
         begin
            if (r_q.cnt == 8'(IM_READ_CYC - 1))
               r_d.im_rdata = r_q.im_mem[r_q.im_addr[IMI-1:0]];
            if (r_q.cnt == 8'(IM_CYCLE_CYC - 1))
               r_d.state = CCMS_IDLE;
         end
         CCMS_IM_WR:
            if (r_q.cnt == 8'(IM_CYCLE_CYC - 1))
            begin
               r_d.im_mem[r_q.im_addr[IMI-1:0]] = r_q.im_wdata;
               r_d.state = CCMS_IDLE;
            end
         CCMS_TM_RD:
            if (r_q.cnt == 8'(TM_CYCLE_CYC - 1))
            begin
               r_d.tm_rdata = r_q.tm_mem[r_q.tm_addr[TMI-1:0]];
               if (^r_d.tm_rdata != 1'b1)
                  r_d.par_err = 1'b1;
               r_d.unit_sel = 8'h0;
               r_d.state = CCMS_IDLE;
            end
         CCMS_TM_WR:
            if (r_q.cnt == 8'(TM_CYCLE_CYC - 1))
            begin
               // odd parity, optionally spoilt to exercise the checker
               r_d.tm_mem[r_q.tm_addr[TMI-1:0]] =
                  {(~^r_q.tm_wdata) ^ r_q.tm_badpar, r_q.tm_wdata};
               r_d.unit_sel = 8'h0;
               r_d.state = CCMS_IDLE;
            end
         default:
            r_d.state = CCMS_IDLE;
      endcase

      // ---------------------------------------------------------
      // duplicated processors
      // ---------------------------------------------------------
      r_d.bus_v = 1'b0;
      if (r_q.tick && CPU_VALID)
      begin
         r_d.bus = r_q.act ? CPU1_WORD : CPU0_WORD;
         r_d.bus_v = 1'b1;
         if (CPU0_WORD != CPU1_WORD)
         begin
            r_d.mism = 1'b1;
            if ((r_q.act ? CPU1_FAULT : CPU0_FAULT) && r_q.sb_ok)
            begin
               r_d.act = ~r_q.act;
               r_d.bus = r_q.act ? CPU0_WORD : CPU1_WORD;
            end
            r_d.sb_ok = 1'b0;
         end
      end

      // ---------------------------------------------------------
      // register bus, write side
      // ---------------------------------------------------------
      if (S_AXI_AWVALID && r_q.awready)
      begin
         r_d.aw_have = 1'b1;
         r_d.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && r_q.wready)
      begin
         r_d.w_have = 1'b1;
         r_d.w_data = S_AXI_WDATA;
         r_d.w_strb = S_AXI_WSTRB;
      end
      if (r_q.bvalid && S_AXI_BREADY)
         r_d.bvalid = 1'b0;
      wr_go = r_q.aw_have && r_q.w_have && !r_q.bvalid;
      if (wr_go)
      begin
         r_d.aw_have = 1'b0;
         r_d.w_have = 1'b0;
         r_d.bvalid = 1'b1;
         r_d.bresp = RESP_OK;
         v = merge(32'h0, r_q.w_data, r_q.w_strb);
         case (r_q.aw_addr)
            OFF_CTRL:
            begin
               r_d.lock_open = v[CTRL_LOCK];
               if (v[CTRL_RESTORE])
                  r_d.sb_ok = 1'b1;
            end
            OFF_IM_ADDR:
               r_d.im_addr = IM_AW'(merge(32'(r_q.im_addr), r_q.w_data, r_q.w_strb));
            OFF_IM_WLO:
               r_d.im_wdata[31:0] = merge(r_q.im_wdata[31:0], r_q.w_data, r_q.w_strb);
            OFF_IM_WHI:
               r_d.im_wdata[IM_W-1:32] =
                  22'(merge(32'(r_q.im_wdata[IM_W-1:32]), r_q.w_data, r_q.w_strb));
            OFF_IM_CMD:
               if (r_q.state == CCMS_IDLE && (v[CMD_READ] || v[CMD_WRITE] || v[CMD_FETCH]))
               begin
                  if (r_q.im_addr[IM_AW-1 -: 2] == BLK_LIMIT)
                     r_d.addr_err = 1'b1;
                  else if (v[CMD_FETCH] && r_q.im_addr[IM_AW-1 -: 2] != BLK_PROG)
                     r_d.fetch_err = 1'b1;
                  else if (v[CMD_WRITE] && r_q.im_addr < PROT_LIMIT && !r_q.lock_open)
                     r_d.prot = 1'b1;
                  else
                     r_d.state = v[CMD_WRITE] ? CCMS_IM_WR : CCMS_IM_RD;
               end
            OFF_TM_ADDR:
               r_d.tm_addr = TM_AW'(merge(32'(r_q.tm_addr), r_q.w_data, r_q.w_strb));
            OFF_TM_DATA:
               r_d.tm_wdata = 16'(merge(32'(r_q.tm_wdata), r_q.w_data, r_q.w_strb));
            OFF_TM_CMD:
               if (r_q.state == CCMS_IDLE && (v[CMD_READ] || v[CMD_WRITE]))
               begin
                  r_d.tm_badpar = v[CMD_BADPAR];
                  r_d.unit_sel = 8'h1 << tu;
                  r_d.tm_start = 1'b1;
                  r_d.state = v[CMD_WRITE] ? CCMS_TM_WR : CCMS_TM_RD;
               end
            OFF_STATUS:
            begin
               // write one to clear; a same-cycle event above already set it
               if (v[ST_PROT] && !(r_q.state == CCMS_IDLE && r_d.prot && !r_q.prot))
                  r_d.prot = r_d.prot & ~(r_q.prot);
               if (v[ST_FETCH])
                  r_d.fetch_err = 1'b0;
               if (v[ST_ADDR])
                  r_d.addr_err = 1'b0;
               if (v[ST_PAR] && !(r_q.state == CCMS_TM_RD &&
                  r_q.cnt == 8'(TM_CYCLE_CYC - 1) && ^r_d.tm_rdata != 1'b1))
                  r_d.par_err = 1'b0;
               if (v[ST_MISM] && !(r_q.tick && CPU_VALID && CPU0_WORD != CPU1_WORD))
                  r_d.mism = 1'b0;
            end
            OFF_IM_RLO, OFF_IM_RHI, OFF_ORDER0, OFF_ORDER1, OFF_LOCATE: ;
            default:
               r_d.bresp = RESP_DEC;
         endcase
      end
      r_d.awready = !r_d.aw_have;
      r_d.wready = !r_d.w_have;

      // ---------------------------------------------------------
      // register bus, read side
      // ---------------------------------------------------------
      if (r_q.rvalid && S_AXI_RREADY)
      begin
         r_d.rvalid = 1'b0;
         r_d.arready = 1'b1;
      end
      if (S_AXI_ARVALID && r_q.arready)
      begin
         r_d.arready = 1'b0;
         r_d.rvalid = 1'b1;
         r_d.rresp = RESP_OK;
         case (S_AXI_ARADDR)
            OFF_CTRL: r_d.rdata = 32'(r_q.lock_open);
            OFF_IM_ADDR: r_d.rdata = 32'(r_q.im_addr);
            OFF_IM_WLO: r_d.rdata = r_q.im_wdata[31:0];
            OFF_IM_WHI: r_d.rdata = 32'(r_q.im_wdata[IM_W-1:32]);
            OFF_IM_RLO: r_d.rdata = r_q.im_rdata[31:0];
            OFF_IM_RHI: r_d.rdata = 32'(r_q.im_rdata[IM_W-1:32]);
            OFF_IM_CMD, OFF_TM_CMD: r_d.rdata = 32'h0;
            OFF_ORDER0: r_d.rdata = order_fields(r_q.im_rdata[IM_W-1 -: ORD_W]);
            OFF_ORDER1: r_d.rdata = order_fields(r_q.im_rdata[ORD_W-1:0]);
            OFF_TM_ADDR: r_d.rdata = 32'(r_q.tm_addr);
            OFF_TM_DATA: r_d.rdata = 32'(r_q.tm_rdata);
            OFF_STATUS: r_d.rdata = st;
            OFF_LOCATE: r_d.rdata = {18'h0, r_q.tm_addr[TM_MOD_LSB +: 2], 1'b0,
                                     tu, 2'h0, r_q.im_addr[IM_MOD_LSB +: 2],
                                     r_q.im_addr[IM_UNIT_LSB +: 4]};
            default:
            begin
               r_d.rdata = 32'h0;
               r_d.rresp = RESP_DEC;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         r_q <= '0;
         r_q.arready <= 1'b1;
         r_q.awready <= 1'b1;
         r_q.wready <= 1'b1;
         r_q.sb_ok <= 1'b1;
         r_q.state <= CCMS_IDLE;
      end
      else
         r_q <= r_d;
   end

   assign S_AXI_AWREADY = r_q.awready;
   assign S_AXI_WREADY = r_q.wready;
   assign S_AXI_BRESP = r_q.bresp;
   assign S_AXI_BVALID = r_q.bvalid;
   assign S_AXI_ARREADY = r_q.arready;
   assign S_AXI_RDATA = r_q.rdata;
   assign S_AXI_RRESP = r_q.rresp;
   assign S_AXI_RVALID = r_q.rvalid;
   assign BUS_OUT = r_q.bus;
   assign BUS_VALID = r_q.bus_v;
   assign ACTIVE_CPU = r_q.act;
   assign MISMATCH = r_q.mism;
   assign BASE_TICK = r_q.tick;
   assign TM_UNIT_SEL = r_q.unit_sel;
   assign TM_START = r_q.tm_start;
endmodule

/* pkg/ccms_pkg.sv */
// How it works
// - instruction words are 54 bits, one access
// - each word holds two orders
// - order splits into opcode, index, address fields
// - opcode splits into group and instruction parts
// - index field names working or tested register
// - address field: address, immediate or options
// - read word at 3.5 us, cycle 6 us
// - protected area writes need open locks
// - unprotected area writable without locks
// - three 65,536-word blocks, 196,608 words total
// - fetches only from the program block
// - 4096-word modules, four per 16,384 unit
// - transient words: 16 bits plus odd parity
// - 2048-word modules, 8192-word units, eight units
// - common control selects unit, starts cycle
// - 16-bit datapath timed at 2 MHz
// - dominant processor drives; other takes over
// - one address moves one whole word
// - mismatch removes faulty processor, work continues
package ccms_pkg;
   localparam int CLK_NS = 25;
   localparam int BASE_HZ = 2000000;
   localparam int TICK_CYC = 1000000000 / (CLK_NS * BASE_HZ);
   localparam int IM_READ_NS = 3500;
   localparam int IM_READ_CYC = IM_READ_NS / CLK_NS;
   localparam int IM_CYCLE_NS = 6000;
   localparam int IM_CYCLE_CYC = IM_CYCLE_NS / CLK_NS;
   localparam int TM_CYCLE_NS = 1000;
   localparam int TM_CYCLE_CYC = TM_CYCLE_NS / CLK_NS;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_IM_ADDR = 8'h04;
   localparam logic [7:0] OFF_IM_WLO = 8'h08;
   localparam logic [7:0] OFF_IM_WHI = 8'h0C;
   localparam logic [7:0] OFF_IM_RLO = 8'h10;
   localparam logic [7:0] OFF_IM_RHI = 8'h14;
   localparam logic [7:0] OFF_IM_CMD = 8'h18;
   localparam logic [7:0] OFF_ORDER0 = 8'h1C;
   localparam logic [7:0] OFF_ORDER1 = 8'h20;
   localparam logic [7:0] OFF_TM_ADDR = 8'h24;
   localparam logic [7:0] OFF_TM_DATA = 8'h28;
   localparam logic [7:0] OFF_TM_CMD = 8'h2C;
   localparam logic [7:0] OFF_STATUS = 8'h30;
   localparam logic [7:0] OFF_LOCATE = 8'h34;
   // command and status bits
   localparam int CMD_READ = 0;
   localparam int CMD_WRITE = 1;
   localparam int CMD_FETCH = 2;
   localparam int CMD_BADPAR = 2;
   localparam int CTRL_LOCK = 0;
   localparam int CTRL_RESTORE = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_PROT = 1;
   localparam int ST_FETCH = 2;
   localparam int ST_PAR = 3;
   localparam int ST_MISM = 4;
   localparam int ST_ACT = 5;
   localparam int ST_SBOK = 6;
   localparam int ST_ADDR = 7;
   // word and order layout
   localparam int IM_W = 54;
   localparam int ORD_W = 27;
   localparam int ORD_GRP_LSB = 24;
   localparam int ORD_INS_LSB = 19;
   localparam int ORD_IDX_LSB = 16;
   localparam int DAR_W = 16;
   // address map
   localparam int IM_AW = 18;
   localparam logic [1:0] BLK_PROG = 2'h0;
   localparam logic [1:0] BLK_LIMIT = 2'h3;
   localparam int IM_UNIT_LSB = 14;
   localparam int IM_MOD_LSB = 12;
   localparam int TM_AW = 16;
   localparam int TM_UNIT_LSB = 13;
   localparam int TM_MOD_LSB = 11;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_DEC = 2'h3;
   typedef enum logic [2:0] {
      CCMS_IDLE = 3'h0,
      CCMS_IM_RD = 3'h1,
      CCMS_IM_WR = 3'h2,
      CCMS_TM_RD = 3'h3,
      CCMS_TM_WR = 3'h4
   } ccms_state_t;
endpackage

/* tb/ccms_cpu_pair.sv */
`timescale 1ns/1ps
module ccms_cpu_pair (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic corrupt,
   output logic [15:0] word0,
   output logic [15:0] word1,
   output logic valid
);
   logic [15:0] nxt;
   assign nxt = word0 + 16'h9E37;
   // ----
   // both processors step together on the base tick
   // ----
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         word0 <= 16'h0000;
         word1 <= 16'h0000;
         valid <= 1'b0;
      end
      else if (tick)
      begin
         word0 <= nxt;
         word1 <= corrupt ? ~nxt : nxt;
         valid <= 1'b1;
      end
   end
endmodule

/* tb/ccms_properties.sv */
`timescale 1ns/1ps
module ccms_properties (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_BVALID,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic [15:0] CPU0_WORD,
   input wire logic [15:0] CPU1_WORD,
   input wire logic CPU_VALID,
   input wire logic [15:0] BUS_OUT,
   input wire logic BUS_VALID,
   input wire logic ACTIVE_CPU,
   input wire logic MISMATCH,
   input wire logic BASE_TICK,
   input wire logic [7:0] TM_UNIT_SEL,
   input wire logic TM_START
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   tick_period_a: assert property (BASE_TICK |-> ##20 BASE_TICK)
      else $error("base tick period wrong");
   tick_gap_a: assert property (BASE_TICK |=> !BASE_TICK [*8])
      else $error("base tick too frequent");
   bus_answer_a: assert property (BASE_TICK && CPU_VALID |=> BUS_VALID)
      else $error("bus word missing");
   bus_cause_a: assert property (BUS_VALID |-> $past(BASE_TICK) && $past(CPU_VALID))
      else $error("bus word without cause");
   match_copy_a: assert property (BASE_TICK && CPU_VALID && CPU0_WORD == CPU1_WORD
      |=> BUS_OUT == $past(CPU0_WORD)) else $error("bus word wrong");
   mism_set_a: assert property (BASE_TICK && CPU_VALID && CPU0_WORD != CPU1_WORD
      |=> MISMATCH) else $error("mismatch not flagged");
   tm_select_a: assert property (TM_START |-> $onehot(TM_UNIT_SEL) ##1 !TM_START)
      else $error("unit select bad");
   tm_cycle_a: assert property (TM_START |-> ##[38:42] TM_UNIT_SEL == 8'h00)
      else $error("unit select stuck");
   rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   cover property (TM_START);
   cover property (MISMATCH && ACTIVE_CPU);
   cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h3);
endmodule
bind ccms_core ccms_properties ccms_properties_i (.SYS_CLK(SYS_CLK), .RESET(RESET),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BRESP(S_AXI_BRESP),
   .CPU0_WORD(CPU0_WORD), .CPU1_WORD(CPU1_WORD), .CPU_VALID(CPU_VALID),
   .BUS_OUT(BUS_OUT), .BUS_VALID(BUS_VALID), .ACTIVE_CPU(ACTIVE_CPU),
   .MISMATCH(MISMATCH), .BASE_TICK(BASE_TICK), .TM_UNIT_SEL(TM_UNIT_SEL),
   .TM_START(TM_START));

/* tb/central_control_memory_subsystem_bench.sv */
`timescale 1ns/1ps
module central_control_memory_subsystem_bench;
   import ccms_pkg::*;
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   logic sys_clk, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, f0 = 1'b0, f1 = 1'b0, corrupt = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, d;
   logic awready, wready, bvalid, arready, rvalid, cvalid, bus_valid, active, mism, tick;
   logic tm_start, act = 1'b0, sb = 1'b1;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] w0, w1, bus_out, td;
   logic [7:0] unit_sel;
   logic [65:0] rq[$];
   logic [1:0] wq[$];
   logic [16:0] bq[$];
   logic [7:0] uq[$];
   logic [63:0] r64;
   int errors = 0, n_tests = 0, cyc = 0, seed = 32'h5CED;
   ccms_core ccms_core_i (.SYS_CLK(sys_clk), .RESET(reset), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .CPU0_WORD(w0), .CPU1_WORD(w1), .CPU_VALID(cvalid),
      .CPU0_FAULT(f0), .CPU1_FAULT(f1), .BUS_OUT(bus_out), .BUS_VALID(bus_valid),
      .ACTIVE_CPU(active), .MISMATCH(mism), .BASE_TICK(tick), .TM_UNIT_SEL(unit_sel),
      .TM_START(tm_start));
   ccms_cpu_pair ccms_cpu_pair_i (.clk(sys_clk), .rst(reset), .tick(tick),
      .corrupt(corrupt), .word0(w0), .word1(w1), .valid(cvalid));
   // ----
   // checking and bus tasks
   // ----
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h got %h", nm, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge sys_clk);
      wq.push_back(er);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            do @(posedge sys_clk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge sys_clk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input logic [1:0] er);
      @(posedge sys_clk);
      rq.push_back({er, m, e});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
   endtask
   // busy polls carry a zero mask, so only their response code is compared
   task automatic idle;
      d = 32'h1;
      while (d[ST_BUSY] !== 1'b0)
         rd(OFF_STATUS, 32'h0, 32'h0, RESP_OK);
   endtask
   function automatic logic [31:0] ord(input logic [26:0] o);
      return {o[26:19], 5'h00, o[18:0]};
   endfunction
   task automatic im(input logic [31:0] a, input logic [31:0] c);
      wr(OFF_IM_ADDR, a, RESP_OK);
      wr(OFF_IM_CMD, c, RESP_OK);
      idle;
   endtask
   // ----
   // result watcher and processor notes
   // ----
   always @(posedge sys_clk)
   begin
      logic [65:0] re;
      logic [16:0] be;
      if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
      begin
         re = rq.pop_front();
         chk("rresp", {30'h0, re[65:64]}, {30'h0, rresp});
         if (re[63:32] != 32'h0)
            chk("rdata", re[31:0], rdata & re[63:32]);
      end
      if (bvalid === 1'b1 && bready === 1'b1 && wq.size() > 0)
         chk("bresp", {30'h0, wq.pop_front()}, {30'h0, bresp});
      if (bus_valid === 1'b1 && bq.size() > 0)
      begin
         be = bq.pop_front();
         chk("bus", {15'h0, be}, {15'h0, active, bus_out});
      end
      if (tm_start === 1'b1 && uq.size() > 0)
         chk("unit", {24'h0, uq.pop_front()}, {24'h0, unit_sel});
      if (reset === 1'b0 && tick === 1'b1 && cvalid === 1'b1)
      begin
         if (w0 !== w1)
         begin
            if ((act ? f1 : f0) && sb)
               act = !act;
            sb = 1'b0;
         end
         bq.push_back({act, act ? w1 : w0});
      end
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         end_of_test;
      end
   end
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ----
   // main sequence
   // ----
   initial
   begin
      logic [53:0] iw;
      logic [31:0] fa [3];
      logic [31:0] fc [3];
      logic [31:0] fe [3];
      int t0;
      fa = '{32'h00020005, 32'h00030000, 32'h00000010};
      fc = '{32'h4, 32'h1, 32'h4};
      fe = '{32'h4, 32'h80, 32'h0};
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      rd(OFF_CTRL, ALL, 32'h0, RESP_OK);
      r64 = {$random(seed), $random(seed)};
      iw = r64[53:0];
      wr(OFF_IM_WLO, iw[31:0], RESP_OK);
      wr(OFF_IM_WHI, {10'h0, iw[53:32]}, RESP_OK);
      im(32'h00020005, 32'h2);
      t0 = cyc;
      im(32'h00020005, 32'h1);
      chk("im cycle", 32'h1, {31'h0, (cyc - t0 >= IM_CYCLE_CYC) && (cyc - t0 < IM_CYCLE_CYC + 24)});
      rd(OFF_IM_RLO, ALL, iw[31:0], RESP_OK);
      rd(OFF_IM_RHI, 32'h003FFFFF, {10'h0, iw[53:32]}, RESP_OK);
      rd(OFF_ORDER0, ALL, ord(iw[53:27]), RESP_OK);
      rd(OFF_ORDER1, ALL, ord(iw[26:0]), RESP_OK);
      im(32'h00000010, 32'h2);
      rd(OFF_STATUS, 32'h2, 32'h2, RESP_OK);
      wr(OFF_STATUS, 32'h2, RESP_OK);
      im(32'h00000010, 32'h1);
      rd(OFF_IM_RLO, ALL, 32'h0, RESP_OK);
      wr(OFF_CTRL, 32'h1, RESP_OK);
      im(32'h00000010, 32'h2);
      im(32'h00000010, 32'h1);
      rd(OFF_IM_RLO, ALL, iw[31:0], RESP_OK);
      wr(OFF_CTRL, 32'h0, RESP_OK);
      for (int i = 0; i < 3; i++)
      begin
         im(fa[i], fc[i]);
         rd(OFF_STATUS, 32'h84, fe[i], RESP_OK);
         wr(OFF_STATUS, 32'h84, RESP_OK);
      end
      for (int u = 0; u < 8; u++)
      begin
         td = 16'($random(seed));
         wr(OFF_TM_ADDR, {16'h0, 3'(u), 2'(u), 8'h00, 3'(u)}, RESP_OK);
         wr(OFF_TM_DATA, {16'h0, td}, RESP_OK);
         uq.push_back(8'h01 << u);
         wr(OFF_TM_CMD, 32'h2, RESP_OK);
         idle;
         uq.push_back(8'h01 << u);
         wr(OFF_TM_CMD, 32'h1, RESP_OK);
         idle;
         rd(OFF_TM_DATA, 32'h1FFFF, {15'h0, ~^td, td}, RESP_OK);
      end
      rd(OFF_STATUS, 32'h8, 32'h0, RESP_OK);
      uq.push_back(8'h80);
      wr(OFF_TM_CMD, 32'h6, RESP_OK);
      idle;
      uq.push_back(8'h80);
      wr(OFF_TM_CMD, 32'h1, RESP_OK);
      idle;
      rd(OFF_STATUS, 32'h8, 32'h8, RESP_OK);
      wr(OFF_IM_ADDR, 32'h0002D000, RESP_OK);
      rd(OFF_LOCATE, ALL, 32'h0000371B, RESP_OK);
      rd(8'h40, ALL, 32'h0, RESP_DEC);
      wr(8'h40, 32'h1, RESP_DEC);
      f0 <= 1'b1;
      corrupt <= 1'b1;
      repeat (2 * TICK_CYC + 5) @(posedge sys_clk);
      corrupt <= 1'b0;
      f0 <= 1'b0;
      repeat (2 * TICK_CYC) @(posedge sys_clk);
      chk("mismatch", 32'h1, {31'h0, mism});
      chk("active", 32'h1, {31'h0, active});
      rd(OFF_STATUS, 32'h70, 32'h30, RESP_OK);
      wr(OFF_CTRL, 32'h2, RESP_OK);
      rd(OFF_STATUS, 32'h40, 32'h40, RESP_OK);
      end_of_test;
   end
endmodule
